//--- hpcr_regs.sv
/*
  Read-only capture register bank for received auxiliary packets, reached
  over the two-wire serial control port.
  Assumes scl and sda are already synchronous to sys_clk, and that the
  packet decoder presents one-cycle update strobes with its data.
*/
// Contract
// - picture type two-bit field, codes fixed
// - audio protection type byte passed unchanged
// - audio payload bytes zero to five consecutive
// - bit 7 flags second code packet
// - bit 6 high when status valid
// - three-bit position field of first packet
// - second payload captured only when continued
// - seven-bit fresh flag registers through map
`timescale 1ns/1ps

module hpcr_regs #(
  parameter logic [6:0] DEV_ADDR = 7'h4c // serial address, value arbitrary
) (
  input  wire logic                 sys_clk,
  input  wire logic                 reset_n,
  input  wire hpcr_pkg::hpcr_mpeg_t  mpeg_in,
  input  wire hpcr_pkg::hpcr_aud_t   aud_in,
  input  wire hpcr_pkg::hpcr_rec_a_t rec_a_in,
  input  wire hpcr_pkg::hpcr_rec_b_t rec_b_in,
  input  wire logic [6:0]           fresh_flags_in,
  input  wire logic                 scl_in,
  input  wire logic                 sda_in,
  output logic                      sda_out,
  output logic                      sda_oe_n
);

  // ----------------------------------------------------------------------
  // reset release
  // ----------------------------------------------------------------------
  logic rst_meta_reg;
  logic rst_n;

  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      rst_meta_reg <= 1'b0;
      rst_n        <= 1'b0;
    end else begin
      rst_meta_reg <= 1'b1;
      rst_n        <= rst_meta_reg;
    end
  end

  // ----------------------------------------------------------------------
  // capture storage
  // ----------------------------------------------------------------------
  logic [7:0] mem_reg [hpcr_pkg::MAP_LEN];
  logic [6:0] fresh_reg;
  wire  [5:0] idx_mpeg   = 6'(hpcr_pkg::MPEG_PICTURE_KIND - hpcr_pkg::MAP_BASE);
  wire  [5:0] idx_type   = 6'(hpcr_pkg::AUDIO_PROTECT_TYPE - hpcr_pkg::MAP_BASE);
  wire  [5:0] idx_pb0    = 6'(hpcr_pkg::AUDIO_PROTECT_BYTE0 - hpcr_pkg::MAP_BASE);
  wire  [5:0] idx_pb5    = 6'(hpcr_pkg::AUDIO_PROTECT_BYTE5 - hpcr_pkg::MAP_BASE);
  wire  [5:0] idx_stat   = 6'(hpcr_pkg::REC_CODE_A_STATUS - hpcr_pkg::MAP_BASE);
  wire  [5:0] idx_b0     = 6'(hpcr_pkg::REC_B_OFS[0] - hpcr_pkg::MAP_BASE);
  wire        cont_saved = mem_reg[idx_stat][hpcr_pkg::CONT_BIT];
  // a second-code packet arriving with a fresh first-code packet uses the new bit
  wire        cont_now   = rec_a_in.upd ? rec_a_in.cont : cont_saved;
  wire        rec_b_take = rec_b_in.upd && cont_now;

  // the only writers are the decoder strobes and the per-clock fresh flag copy; the serial port has no path here
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      for (int i = 0; i < hpcr_pkg::MAP_LEN; i++) begin
        mem_reg[i] <= hpcr_pkg::BYTE_RESET;
      end
      fresh_reg <= '0;
    end else begin
      fresh_reg <= fresh_flags_in;
      if (mpeg_in.upd) begin
        mem_reg[idx_mpeg] <= {6'h00, mpeg_in.kind};
      end
      if (aud_in.upd) begin
        mem_reg[idx_type] <= aud_in.kind;
        for (int i = 0; i < hpcr_pkg::AUD_BYTES; i++) begin
          mem_reg[6'(idx_pb0 + 6'(i))] <= aud_in.pb[i];
        end
      end
      if (rec_a_in.upd) begin
        mem_reg[idx_stat] <= {rec_a_in.cont, rec_a_in.valid, 3'h0, rec_a_in.pos};
        for (int i = 0; i < hpcr_pkg::REC_BYTES; i++) begin
          mem_reg[6'(hpcr_pkg::REC_A_OFS[i] - hpcr_pkg::MAP_BASE)] <= rec_a_in.pb[i];
        end
      end
      if (rec_b_take) begin
        for (int i = 0; i < hpcr_pkg::REC_BYTES; i++) begin
          mem_reg[6'(hpcr_pkg::REC_B_OFS[i] - hpcr_pkg::MAP_BASE)] <= rec_b_in.pb[i];
        end
      end
    end
  end

  // ----------------------------------------------------------------------
  // read selection
  // ----------------------------------------------------------------------
  logic [7:0] ptr_reg;
  wire        ptr_fresh = (ptr_reg == hpcr_pkg::FRESH_FLAGS_A) ||
                          (ptr_reg == hpcr_pkg::FRESH_FLAGS_B) ||
                          (ptr_reg == hpcr_pkg::FRESH_FLAGS_C) ||
                          (ptr_reg == hpcr_pkg::FRESH_FLAGS_D) ||
                          (ptr_reg == hpcr_pkg::FRESH_FLAGS_E);
  wire        ptr_in_map = (ptr_reg >= hpcr_pkg::MAP_BASE) &&
                           (ptr_reg <= hpcr_pkg::MAP_LAST);
  wire  [5:0] ptr_idx   = 6'(ptr_reg - hpcr_pkg::MAP_BASE);
  logic [7:0] rd_byte;

  assign rd_byte = ptr_fresh  ? {1'b0, fresh_reg} :
                   ptr_in_map ? mem_reg[ptr_idx]   : hpcr_pkg::BYTE_RESET;

  // ----------------------------------------------------------------------
  // two-wire serial slave
  // ----------------------------------------------------------------------
  hpcr_pkg::hpcr_state_t state_reg;
  logic       scl_q;
  logic       sda_q;
  logic [2:0] cnt_reg;
  logic       done_reg;
  logic [7:0] sh_reg;
  logic [7:0] tx_reg;
  logic       nack_reg;
  logic       fetch_reg;

  wire scl_rise = scl_in && !scl_q;
  wire scl_fall = !scl_in && scl_q;
  wire start_ev = scl_in && scl_q && sda_q && !sda_in;
  wire stop_ev  = scl_in && scl_q && !sda_q && sda_in;
  wire addr_hit = (sh_reg[7:1] == DEV_ADDR);
  wire fall_only = scl_fall && !start_ev && !stop_ev;
  // acknowledge slots are not data bits: shifting there would eat the direction bit
  wire bit_phase = (state_reg == hpcr_pkg::HPCR_ADDR) ||
                   (state_reg == hpcr_pkg::HPCR_PTR) ||
                   (state_reg == hpcr_pkg::HPCR_WDATA) ||
                   (state_reg == hpcr_pkg::HPCR_RDATA);

  assign sda_out = 1'b0;

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      scl_q <= 1'b1;
      sda_q <= 1'b1;
    end else begin
      scl_q <= scl_in;
      sda_q <= sda_in;
    end
  end

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      state_reg <= hpcr_pkg::HPCR_IDLE;
      cnt_reg   <= '0;
      done_reg  <= 1'b0;
      sh_reg    <= '0;
      tx_reg    <= '0;
      ptr_reg   <= '0;
      nack_reg  <= 1'b0;
      sda_oe_n  <= 1'b1;
    end else if (start_ev) begin
      state_reg <= hpcr_pkg::HPCR_ADDR;
      cnt_reg   <= '0;
      done_reg  <= 1'b0;
      sda_oe_n  <= 1'b1;
    end else if (stop_ev) begin
      state_reg <= hpcr_pkg::HPCR_IDLE;
      sda_oe_n  <= 1'b1;
    end else if (scl_rise) begin
      if (state_reg == hpcr_pkg::HPCR_RACK) begin
        nack_reg <= sda_in;
      end else if (bit_phase) begin
        sh_reg   <= {sh_reg[6:0], sda_in};
        cnt_reg  <= cnt_reg + 3'h1;
        done_reg <= (cnt_reg == hpcr_pkg::BIT_LAST);
      end
    end else if (scl_fall) begin
      done_reg <= 1'b0;
      case (state_reg)
        hpcr_pkg::HPCR_ADDR: begin
          if (done_reg && addr_hit) begin
            state_reg <= hpcr_pkg::HPCR_AACK;
            sda_oe_n  <= 1'b0;
          end else if (done_reg) begin
            state_reg <= hpcr_pkg::HPCR_IDLE;
          end
        end
        hpcr_pkg::HPCR_AACK: begin
          if (sh_reg[0]) begin
            state_reg <= hpcr_pkg::HPCR_RDATA;
            tx_reg    <= {rd_byte[6:0], 1'b0};
            sda_oe_n  <= rd_byte[7];
          end else begin
            state_reg <= hpcr_pkg::HPCR_PTR;
            sda_oe_n  <= 1'b1;
          end
        end
        hpcr_pkg::HPCR_PTR: begin
          if (done_reg) begin
            state_reg <= hpcr_pkg::HPCR_PACK;
            ptr_reg   <= sh_reg;
            sda_oe_n  <= 1'b0;
          end
        end
        hpcr_pkg::HPCR_PACK: begin
          state_reg <= hpcr_pkg::HPCR_WDATA;
          sda_oe_n  <= 1'b1;
        end
        hpcr_pkg::HPCR_WDATA: begin
          if (done_reg) begin
            state_reg <= hpcr_pkg::HPCR_WACK;
            sda_oe_n  <= 1'b0;
          end
        end
        hpcr_pkg::HPCR_WACK: begin
          state_reg <= hpcr_pkg::HPCR_WDATA;
          ptr_reg   <= ptr_reg + 8'h01;
          sda_oe_n  <= 1'b1;
        end
        hpcr_pkg::HPCR_RDATA: begin
          if (done_reg) begin
            state_reg <= hpcr_pkg::HPCR_RACK;
            sda_oe_n  <= 1'b1;
          end else begin
            tx_reg   <= {tx_reg[6:0], 1'b0};
            sda_oe_n <= tx_reg[7];
          end
        end
        hpcr_pkg::HPCR_RACK: begin
          // master nack ends the read; the pointer still moves past the last byte
          ptr_reg <= ptr_reg + 8'h01;
          if (nack_reg) begin
            state_reg <= hpcr_pkg::HPCR_IDLE;
          end else begin
            state_reg <= hpcr_pkg::HPCR_RDATA;
          end
        end
        default: begin
          state_reg <= hpcr_pkg::HPCR_IDLE;
        end
      endcase
    end else if (fetch_reg) begin
      tx_reg   <= {rd_byte[6:0], 1'b0};
      sda_oe_n <= rd_byte[7];
    end
  end

  // next byte is fetched after the pointer steps, one clock after the ack fall
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      fetch_reg <= 1'b0;
    end else begin
      fetch_reg <= scl_fall && (state_reg == hpcr_pkg::HPCR_RACK) && !nack_reg &&
                   !start_ev && !stop_ev;
    end
  end

  // ----------------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------------
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!rst_n);

  mpeg_field_a: assert property (
    mpeg_in.upd |=> mem_reg[idx_mpeg] == {6'h00, $past(mpeg_in.kind)})
    else $error("picture type field not captured");

  aud_type_a: assert property (
    aud_in.upd |=> mem_reg[idx_type] == $past(aud_in.kind))
    else $error("audio protection type not captured");

  aud_last_a: assert property (
    aud_in.upd |=> mem_reg[idx_pb5] == $past(aud_in.pb[5]) &&
                   mem_reg[idx_pb0] == $past(aud_in.pb[0]))
    else $error("audio protection payload misplaced");

  cont_bit_a: assert property (
    rec_a_in.upd |=> cont_saved == $past(rec_a_in.cont))
    else $error("continuation bit wrong");

  valid_bit_a: assert property (
    rec_a_in.upd ##1 !rec_a_in.upd |=> mem_reg[idx_stat][hpcr_pkg::VALID_BIT] ==
                                       $past(rec_a_in.valid, 2))
    else $error("valid bit wrong");

  position_a: assert property (
    rec_a_in.upd |=> mem_reg[idx_stat][2:0] == $past(rec_a_in.pos) &&
                     mem_reg[idx_stat][5:3] == 3'h0)
    else $error("position field wrong");

  recb_gate_a: assert property (
    rec_b_in.upd && !cont_now |=> $stable(mem_reg[idx_b0]))
    else $error("second payload taken without continuation");

  fresh_read_a: assert property (
    ptr_fresh |-> rd_byte == {1'b0, $past(fresh_flags_in)})
    else $error("fresh flag copy wrong");

  sequence read_start_s;
    scl_fall && !start_ev && !stop_ev && state_reg == hpcr_pkg::HPCR_AACK && sh_reg[0];
  endsequence

  read_load_a: assert property (
    read_start_s |=> state_reg == hpcr_pkg::HPCR_RDATA &&
                     sda_oe_n == $past(rd_byte[7]))
    else $error("read byte not loaded");

  hold_write_a: assert property (
    !aud_in.upd |=> $stable(mem_reg[idx_pb0]))
    else $error("payload changed without update");

  recb_take_a: assert property (
    rec_b_in.upd && cont_now |=> mem_reg[idx_b0] == $past(rec_b_in.pb[0]))
    else $error("second payload not taken with continuation");

  unmapped_zero_a: assert property (
    !ptr_in_map && !ptr_fresh |-> rd_byte == hpcr_pkg::BYTE_RESET)
    else $error("unmapped read not zero");

  // ----------------------------------------------------------------------
  // serial port checks
  // ----------------------------------------------------------------------
  sequence addr_done_s;
    fall_only && state_reg == hpcr_pkg::HPCR_ADDR && done_reg;
  endsequence

  sequence rack_fall_s;
    fall_only && state_reg == hpcr_pkg::HPCR_RACK;
  endsequence

  sequence wack_fall_s;
    fall_only && state_reg == hpcr_pkg::HPCR_WACK;
  endsequence

  addr_ack_a: assert property (
    addr_done_s ##0 addr_hit |=> state_reg == hpcr_pkg::HPCR_AACK && !sda_oe_n)
    else $error("own address not acknowledged");

  addr_miss_a: assert property (
    addr_done_s ##0 !addr_hit |=> state_reg == hpcr_pkg::HPCR_IDLE && sda_oe_n)
    else $error("foreign address acknowledged");

  data_ack_a: assert property (
    fall_only && state_reg == hpcr_pkg::HPCR_WDATA && done_reg |=>
      state_reg == hpcr_pkg::HPCR_WACK && !sda_oe_n)
    else $error("write data not acknowledged");

  write_step_a: assert property (
    wack_fall_s |=> ptr_reg == $past(ptr_reg) + 8'h01 &&
                    state_reg == hpcr_pkg::HPCR_WDATA)
    else $error("pointer not stepped after write byte");

  read_step_a: assert property (
    rack_fall_s |=> ptr_reg == $past(ptr_reg) + 8'h01)
    else $error("pointer not stepped after read byte");

  // the fetch edge never meets a bus edge with the host model's phase lengths
  next_load_a: assert property (
    fetch_reg && !start_ev && !stop_ev && !scl_rise && !scl_fall |=>
      sda_oe_n == $past(rd_byte[7]))
    else $error("next read byte not loaded");

  stop_idle_a: assert property (
    stop_ev |=> state_reg == hpcr_pkg::HPCR_IDLE && sda_oe_n)
    else $error("stop did not release the bus");

  bus_idle_a: assert property (
    state_reg == hpcr_pkg::HPCR_IDLE |-> sda_oe_n)
    else $error("data line held while idle");

endmodule

//--- hpcr_pkg.sv
/*
  Package for the received-packet capture register bank: map offsets,
  field positions, reset values, capture structs and the serial port states.
  Assumes the consumer refers to every item as hpcr_pkg::name.
*/
package hpcr_pkg;

  // ----------------------------------------------------------------------
  // register map
  // ----------------------------------------------------------------------
  localparam logic [7:0] MAP_BASE          = 8'hbd;
  localparam int         MAP_LEN           = 50;
  localparam logic [7:0] MAP_LAST          = 8'hee;
  localparam logic [7:0] MPEG_PICTURE_KIND = 8'hbd;
  localparam logic [7:0] RESERVED_BE       = 8'hbe;
  localparam logic [7:0] FRESH_FLAGS_A     = 8'hbf;
  localparam logic [7:0] AUDIO_PROTECT_TYPE = 8'hc0;
  localparam logic [7:0] AUDIO_PROTECT_BYTE0 = 8'hc1;
  localparam logic [7:0] AUDIO_PROTECT_BYTE5 = 8'hc6;
  localparam logic [7:0] FRESH_FLAGS_B     = 8'hc7;
  localparam logic [7:0] REC_CODE_A_STATUS = 8'hc8;
  localparam logic [7:0] FRESH_FLAGS_C     = 8'hcf;
  localparam logic [7:0] FRESH_FLAGS_D     = 8'hd7;
  localparam logic [7:0] FRESH_FLAGS_E     = 8'he7;

  localparam int AUD_BYTES = 6;
  localparam int REC_BYTES = 17;

  // per-byte addresses of the two recording-code payloads
  localparam logic [7:0] REC_A_OFS [REC_BYTES] = '{
    8'hc9, 8'hca, 8'hcb, 8'hcc, 8'hcd, 8'hce, 8'hd0, 8'hd1, 8'hd2,
    8'hd3, 8'hd4, 8'hd5, 8'hd6, 8'hd8, 8'hd9, 8'hda, 8'hde};
  localparam logic [7:0] REC_B_OFS [REC_BYTES] = '{
    8'hdb, 8'hdc, 8'hdd, 8'he0, 8'he1, 8'he2, 8'he3, 8'he4, 8'he5,
    8'he6, 8'he8, 8'he9, 8'hea, 8'heb, 8'hec, 8'hed, 8'hee};

  // ----------------------------------------------------------------------
  // field layout
  // ----------------------------------------------------------------------
  localparam int CONT_BIT   = 7;
  localparam int VALID_BIT  = 6;
  localparam int FLAG_W     = 7;
  localparam logic [7:0] BYTE_RESET = 8'h00;
  localparam logic [2:0] BIT_LAST   = 3'h7;

  typedef enum logic [1:0] {
    HPCR_PIC_UNKNOWN = 2'h0,
    HPCR_PIC_INTRA   = 2'h1,
    HPCR_PIC_BIDIR   = 2'h2,
    HPCR_PIC_PRED    = 2'h3
  } hpcr_pic_t;

  typedef enum logic [2:0] {
    HPCR_POS_START = 3'h1,
    HPCR_POS_MID   = 3'h2,
    HPCR_POS_FINAL = 3'h4
  } hpcr_pos_t;

  // ----------------------------------------------------------------------
  // capture carriers from the packet decoder
  // ----------------------------------------------------------------------
  typedef struct packed {
    logic      upd;
    hpcr_pic_t kind;
  } hpcr_mpeg_t;

  typedef struct packed {
    logic                      upd;
    logic [7:0]                kind;
    logic [AUD_BYTES-1:0][7:0] pb;
  } hpcr_aud_t;

  typedef struct packed {
    logic                      upd;
    logic                      cont;
    logic                      valid;
    hpcr_pos_t                 pos;
    logic [REC_BYTES-1:0][7:0] pb;
  } hpcr_rec_a_t;

  typedef struct packed {
    logic                      upd;
    logic [REC_BYTES-1:0][7:0] pb;
  } hpcr_rec_b_t;

  // ----------------------------------------------------------------------
  // two-wire serial port states
  // ----------------------------------------------------------------------
  typedef enum logic [3:0] {
    HPCR_IDLE  = 4'h0,
    HPCR_ADDR  = 4'h1,
    HPCR_AACK  = 4'h3,
    HPCR_PTR   = 4'h2,
    HPCR_PACK  = 4'h6,
    HPCR_WDATA = 4'h7,
    HPCR_WACK  = 4'h5,
    HPCR_RDATA = 4'h4,
    HPCR_RACK  = 4'hc
  } hpcr_state_t;

endpackage

//--- hpcr_host.sv
/*
  Two-wire host model: start, stop, byte write and byte read by bit-banging.
  Assumes the bench resolves the open-drain data wire with a pull-up.
*/
`timescale 1ns/1ps
module hpcr_host #(
  parameter int Q = 2
) (
  input  wire logic  sys_clk,
  input  wire logic  sda,
  output logic       scl,
  output logic       sda_low,
  output logic       res_valid,
  output logic [7:0] res_data
);
  // ------------------------------------------------------------
  // bus phases, Q clocks a quarter bit
  // ------------------------------------------------------------
  initial begin
    scl = 1'b1;
    sda_low = 1'b0;
    res_valid = 1'b0;
    res_data = 8'h00;
  end

  task automatic qwait();
    repeat (Q) @(posedge sys_clk);
  endtask

  // also a repeated start: data released before the clock rises
  task automatic start_c();
    sda_low <= 1'b0;
    qwait();
    scl <= 1'b1;
    qwait();
    sda_low <= 1'b1;
    qwait();
    scl <= 1'b0;
    qwait();
  endtask

  task automatic stop_c();
    sda_low <= 1'b1;
    qwait();
    scl <= 1'b1;
    qwait();
    sda_low <= 1'b0;
    qwait();
  endtask

  // data only moves while the clock is low, well clear of either edge
  task automatic bit_x(input logic b, output logic got);
    sda_low <= ~b;
    qwait();
    scl <= 1'b1;
    qwait();
    got = sda;
    qwait();
    scl <= 1'b0;
    qwait();
  endtask

  task automatic put_byte(input logic [7:0] v, output logic ack);
    logic g;
    for (int i = 7; i >= 0; i--) bit_x(v[i], g);
    bit_x(1'b1, g);
    ack = ~g;
  endtask

  task automatic get_byte(input logic last);
    logic [7:0] v;
    logic       g;
    for (int i = 7; i >= 0; i--) begin
      bit_x(1'b1, g);
      v[i] = g;
    end
    bit_x(last, g);
    res_data <= v;
    res_valid <= 1'b1;
    @(posedge sys_clk);
    res_valid <= 1'b0;
  endtask

  task automatic read_seq(input logic [6:0] dev, input logic [7:0] ptr, input int n,
                          output logic ack);
    logic a0, a1, a2;
    start_c();
    put_byte({dev, 1'b0}, a0);
    put_byte(ptr, a1);
    start_c();
    put_byte({dev, 1'b1}, a2);
    for (int k = 0; k < n; k++) get_byte(k == n - 1);
    stop_c();
    ack = a0 & a1 & a2;
  endtask

  task automatic write_seq(input logic [6:0] dev, input logic [7:0] ptr, v,
                           output logic ack);
    logic a0, a1, a2;
    start_c();
    put_byte({dev, 1'b0}, a0);
    put_byte(ptr, a1);
    put_byte(v, a2);
    stop_c();
    ack = a0 & a1 & a2;
  endtask
endmodule

//--- test_hdmi_packet_capture_regs.sv
/*
  Self-checking bench for the capture register bank: a shadow map of
  expected contents, read back through the two-wire host model.
  Assumes the bank's serial slave address is DEV.
*/
`timescale 1ns/1ps
`define CHK(g, e) begin cmp_count++; if ((g) !== (e)) begin n_errors++; \
  $display("mismatch t=%0t got %h exp %h", $time, g, e); end end
module test_hdmi_packet_capture_regs;
  localparam logic [6:0] DEV = 7'h4c;
  logic                   sys_clk = 1'b0;
  logic                   reset_n = 1'b0;
  hpcr_pkg::hpcr_mpeg_t   mpeg_in = '0;
  hpcr_pkg::hpcr_aud_t    aud_in = '0;
  hpcr_pkg::hpcr_rec_a_t  rec_a_in = '0;
  hpcr_pkg::hpcr_rec_b_t  rec_b_in = '0;
  logic [6:0]             fresh_flags_in = 7'h00;
  logic                   scl, sda_low, sda_out, sda_oe_n, res_valid, ack;
  logic [7:0]             res_data, exp_b, ty;
  logic [5:0][7:0]        ab;
  logic [6:0]             fl;
  logic [7:0]             shadow [256];
  logic [7:0]             expq [$];
  logic [7:0]             ffa [5] = '{8'hbf, 8'hc7, 8'hcf, 8'hd7, 8'he7};
  hpcr_pkg::hpcr_pos_t    poss [3] = '{hpcr_pkg::HPCR_POS_START, hpcr_pkg::HPCR_POS_MID,
                                       hpcr_pkg::HPCR_POS_FINAL};
  int                     n_errors = 0;
  int                     cmp_count = 0;
  // pull-up on the open-drain data wire
  wire                    sda = ~sda_low & (sda_oe_n | sda_out);

  always #50 sys_clk = ~sys_clk;

  hpcr_regs #(.DEV_ADDR(DEV)) uut (.sys_clk, .reset_n, .mpeg_in, .aud_in, .rec_a_in,
    .rec_b_in, .fresh_flags_in, .scl_in(scl), .sda_in(sda), .sda_out, .sda_oe_n);
  hpcr_host host (.sys_clk, .sda, .scl, .sda_low, .res_valid, .res_data);

  // ------------------------------------------------------------
  // result watcher and shared tasks
  // ------------------------------------------------------------
  always @(posedge sys_clk) begin
    if (res_valid === 1'b1) begin
      exp_b = expq.pop_front();
      `CHK(res_data, exp_b)
    end
  end

  task automatic strobe();
    @(posedge sys_clk);
    mpeg_in.upd <= 1'b0;
    aud_in.upd <= 1'b0;
    rec_a_in.upd <= 1'b0;
    rec_b_in.upd <= 1'b0;
  endtask

  task automatic check_map(input logic [7:0] a, input int n);
    for (int k = 0; k < n; k++) expq.push_back(shadow[a + k]);
    host.read_seq(DEV, a, n, ack);
    `CHK(ack, 1'b1)
  endtask

  // second payload only lands while the continuation is set
  task automatic load_rec(input logic au, cont, valid, input hpcr_pkg::hpcr_pos_t pos,
                          input logic bu);
    logic [16:0][7:0] pa, pb;
    logic             eff;
    for (int i = 0; i < 17; i++) begin
      pa[i] = 8'($urandom);
      pb[i] = 8'($urandom);
    end
    eff = au ? cont : shadow[8'hc8][7];
    @(posedge sys_clk);
    rec_a_in <= '{au, cont, valid, pos, pa};
    rec_b_in <= '{bu, pb};
    strobe();
    if (au) shadow[8'hc8] = {cont, valid, 3'h0, pos};
    for (int i = 0; i < 17; i++) begin
      if (au) shadow[hpcr_pkg::REC_A_OFS[i]] = pa[i];
      if (bu && eff) shadow[hpcr_pkg::REC_B_OFS[i]] = pb[i];
    end
  endtask

  task automatic complete_run();
    $display("comparisons %0d mismatches %0d", cmp_count, n_errors);
    if (n_errors == 0 && cmp_count > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask

  // ------------------------------------------------------------
  // tests
  // ------------------------------------------------------------
  initial begin
    void'($urandom(32'h19eccb41));
    foreach (shadow[i]) shadow[i] = 8'h00;
    repeat (10) @(posedge sys_clk);
    reset_n <= 1'b1;
    repeat (5) @(posedge sys_clk);
    `CHK(sda_out, 1'b0)
    check_map(8'hbd, 50);
    $display("test reset map done");
    for (int t = 0; t < 5; t++) begin
      ty = (t < 4) ? 8'(t) : 8'(4 + $urandom_range(251));
      for (int i = 0; i < 6; i++) ab[i] = 8'($urandom);
      fl = 7'($urandom);
      @(posedge sys_clk);
      mpeg_in <= '{1'b1, hpcr_pkg::hpcr_pic_t'(2'(t))};
      aud_in <= '{1'b1, ty, ab};
      fresh_flags_in <= fl;
      strobe();
      shadow[8'hbd] = {6'h00, 2'(t)};
      shadow[8'hc0] = ty;
      for (int i = 0; i < 6; i++) shadow[8'hc1 + i] = ab[i];
      foreach (ffa[j]) shadow[ffa[j]] = {1'b0, fl};
      check_map(8'hbd, 11);
    end
    $display("test picture and audio done");
    for (int p = 0; p < 3; p++) begin
      load_rec(1'b1, p != 2, p != 1, poss[p], p != 1);
      if (p != 0) load_rec(1'b0, 1'b0, 1'b0, poss[p], 1'b1);
      check_map(8'hc8, 39);
    end
    $display("test recording code done");
    host.write_seq(DEV, 8'hc1, ~shadow[8'hc1], ack);
    `CHK(ack, 1'b1)
    host.write_seq(DEV ^ 7'h01, 8'hc1, 8'(~$urandom), ack);
    `CHK(ack, 1'b0)
    check_map(8'hbd, 50);
    $display("test write ignored done");
    complete_run();
  end

  // about two and a half times the expected run length
  initial begin
    repeat (60000) @(posedge sys_clk);
    n_errors++;
    complete_run();
  end
endmodule
